// [rtl/prc_defs.svh]
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH
// Register byte offsets
`define PRC_OFF_CTRL 12'h000
`define PRC_OFF_STATUS 12'h004
`define PRC_OFF_IRQ_STAT 12'h008
`define PRC_OFF_IRQ_MASK 12'h00C
`define PRC_OFF_ERR_OFS 12'h010
`define PRC_OFF_PARAM 12'h100
`define PRC_OFF_G1_LIVE 12'h200
`define PRC_OFF_G2_LIVE 12'h300
`define PRC_OFF_LIMIT 12'h400
// Parameter area layout
`define PRC_NUM_WORDS 32
`define PRC_G1_WORDS 8
`define PRC_G2_WORDS 16
`define PRC_EXP_BASE 16
`define PRC_EXP_OFS 16'h0064
`define PRC_LIMIT_RST 16'h7FFF
// Field positions
`define PRC_CTRL_RESTART 0
`define PRC_ST_RUN 0
`define PRC_ST_ERR 1
`define PRC_IRQ_G1ERR 0
`define PRC_IRQ_BLOCK 1
`define PRC_IRQ_START 2
`define PRC_IRQ_W 3
// AXI responses
`define PRC_RESP_OKAY 2'h0
`define PRC_RESP_SLVERR 2'h2
`endif

// [rtl/prc_pkg.sv]
package prc_pkg;
  typedef enum logic [2:0] {
    PRC_INIT = 3'h1,
    PRC_RUN = 3'h2,
    PRC_HALT = 3'h4
  } prc_mode_t;
  typedef struct packed {
    logic busy;
    logic [7:0] idx;
  } prc_scan_t;
endpackage : prc_pkg

// [rtl/prc_unit.sv]
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "prc_defs.svh"
module prc_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic run_indicator,
  output logic setting_error_indicator,
  output logic [15:0] error_offset_value,
  output logic irq
);
  localparam int NW = `PRC_NUM_WORDS;

  typedef struct packed {
    prc_pkg::prc_mode_t mode;
    prc_pkg::prc_scan_t scan;
    logic [NW-1:0][15:0] param;
    logic [NW-1:0][15:0] limit;
    logic [NW-1:0][15:0] live;
    logic [NW-1:0] bad;
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic run;
    logic err;
    logic [15:0] ofs;
    logic [`PRC_IRQ_W-1:0] irq_stat;
    logic [`PRC_IRQ_W-1:0] irq_mask;
    logic irq;
  } prc_state_t;

  prc_state_t r;
  prc_state_t next_r;

  // Per-word range check against its limit
  logic [NW-1:0] word_bad;
  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++) begin : g_chk
      assign word_bad[gi] = r.param[gi] > r.limit[gi];
    end
  endgenerate

  // Lowest-index erroneous word
  function automatic logic [15:0] prc_lowest(input logic [NW-1:0] v);
    logic [15:0] res;
    res = 16'h0000;
    for (int i = NW - 1; i >= 0; i--) begin
      if (v[i]) begin
        if (i >= `PRC_EXP_BASE) begin
          res = `PRC_EXP_OFS + 16'(i - `PRC_EXP_BASE);
        end else begin
          res = 16'(i);
        end
      end
    end
    return res;
  endfunction : prc_lowest

  function automatic logic prc_is_g1(input int i);
    return i < `PRC_G1_WORDS;
  endfunction : prc_is_g1

  logic do_write;
  logic [9:0] wword;
  logic [9:0] rword;
  logic [NW-1:0] live_bad;
  logic any_bad;
  logic g1_pending;

  always_comb begin
    next_r = r;
    do_write = r.aw_got && r.w_got && !r.bvalid;
    wword = r.awaddr[11:2];
    rword = s_axi_araddr[11:2];
    live_bad = word_bad;
    any_bad = |word_bad;
    g1_pending = 1'b0;
    for (int i = 0; i < NW; i++) begin
      if (prc_is_g1(i) && word_bad[i]) begin
        g1_pending = 1'b1;
      end
    end

    // Write address and data taken in either order
    next_r.awready = !r.aw_got && !s_axi_awvalid ? 1'b1 : !r.aw_got && !r.awready;
    next_r.wready = !r.w_got && !s_axi_wvalid ? 1'b1 : !r.w_got && !r.wready;
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
      next_r.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
      next_r.wready = 1'b0;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Group 1 words follow the host continuously while running and in range
    if (r.mode == prc_pkg::PRC_RUN) begin
      for (int i = 0; i < NW; i++) begin
        if (prc_is_g1(i) && !word_bad[i]) begin
          next_r.live[i] = r.param[i];
        end
      end
    end

    // Host register writes; a same-cycle hardware set below wins over a clear here
    if (do_write) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `PRC_RESP_OKAY;
      if (r.awaddr == `PRC_OFF_CTRL) begin
        if (r.wstrb[0] && r.wdata[`PRC_CTRL_RESTART]) begin
          next_r.mode = prc_pkg::PRC_INIT;
          next_r.scan = '{busy: 1'b1, idx: 8'h00};
        end
      end else if (r.awaddr == `PRC_OFF_IRQ_STAT) begin
        if (r.wstrb[0]) begin
          next_r.irq_stat = r.irq_stat & ~r.wdata[`PRC_IRQ_W-1:0];
        end
      end else if (r.awaddr == `PRC_OFF_IRQ_MASK) begin
        if (r.wstrb[0]) begin
          next_r.irq_mask = r.wdata[`PRC_IRQ_W-1:0];
        end
      end else if (wword >= 10'(`PRC_OFF_PARAM >> 2) && wword < 10'((`PRC_OFF_PARAM >> 2) + NW)) begin
        // Host parameter area: stored raw, checked live
        for (int b = 0; b < 2; b++) begin
          if (r.wstrb[b]) begin
            next_r.param[5'(wword)][b*8 +: 8] = r.wdata[b*8 +: 8];
          end
        end
      end else if (wword >= 10'(`PRC_OFF_LIMIT >> 2) && wword < 10'((`PRC_OFF_LIMIT >> 2) + NW)) begin
        for (int b = 0; b < 2; b++) begin
          if (r.wstrb[b]) begin
            next_r.limit[5'(wword)][b*8 +: 8] = r.wdata[b*8 +: 8];
          end
        end
      end else begin
        next_r.bresp = `PRC_RESP_SLVERR;
      end
    end

    // Restart: one cycle to sample, then decide
    case (r.mode)
      prc_pkg::PRC_INIT: begin
        next_r.scan.busy = 1'b0;
        next_r.bad = word_bad;
        if (any_bad) begin
          next_r.mode = prc_pkg::PRC_HALT;
          next_r.run = 1'b0;
          next_r.err = 1'b1;
          next_r.irq_stat[`PRC_IRQ_BLOCK] = 1'b1;
        end else begin
          next_r.mode = prc_pkg::PRC_RUN;
          next_r.run = 1'b1;
          next_r.err = 1'b0;
          next_r.live = r.param;
          next_r.irq_stat[`PRC_IRQ_START] = 1'b1;
        end
        next_r.ofs = prc_lowest(word_bad);
      end
      prc_pkg::PRC_RUN: begin
        // Group 2 and expansion values stay frozen while running
        next_r.run = 1'b1;
        next_r.err = g1_pending;
        next_r.ofs = prc_lowest(live_bad);
        if (g1_pending && !r.err) begin
          next_r.irq_stat[`PRC_IRQ_G1ERR] = 1'b1;
        end
      end
      prc_pkg::PRC_HALT: begin
        // Stays halted until host fixes values and restarts
        next_r.run = 1'b0;
        next_r.err = 1'b1;
        next_r.ofs = prc_lowest(word_bad);
      end
      default: begin
        next_r.mode = prc_pkg::PRC_INIT;
      end
    endcase

    // Read channel
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    // Ready only while no read answer is pending; a take drops it below
    next_r.arready = !r.rvalid;
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = `PRC_RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      if (s_axi_araddr == `PRC_OFF_CTRL) begin
        next_r.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == `PRC_OFF_STATUS) begin
        next_r.rdata[`PRC_ST_RUN] = r.run;
        next_r.rdata[`PRC_ST_ERR] = r.err;
      end else if (s_axi_araddr == `PRC_OFF_IRQ_STAT) begin
        next_r.rdata[`PRC_IRQ_W-1:0] = r.irq_stat;
      end else if (s_axi_araddr == `PRC_OFF_IRQ_MASK) begin
        next_r.rdata[`PRC_IRQ_W-1:0] = r.irq_mask;
      end else if (s_axi_araddr == `PRC_OFF_ERR_OFS) begin
        next_r.rdata[15:0] = r.ofs;
      end else if (rword >= 10'(`PRC_OFF_PARAM >> 2) && rword < 10'((`PRC_OFF_PARAM >> 2) + NW)) begin
        next_r.rdata[15:0] = r.param[5'(rword)];
      end else if (rword >= 10'(`PRC_OFF_G1_LIVE >> 2) && rword < 10'((`PRC_OFF_G1_LIVE >> 2) + NW)) begin
        next_r.rdata[15:0] = r.live[5'(rword)];
      end else if (rword >= 10'(`PRC_OFF_LIMIT >> 2) && rword < 10'((`PRC_OFF_LIMIT >> 2) + NW)) begin
        next_r.rdata[15:0] = r.limit[5'(rword)];
      end else begin
        next_r.rresp = `PRC_RESP_SLVERR;
      end
    end

    next_r.irq = |(next_r.irq_stat & r.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.mode <= prc_pkg::PRC_INIT;
      r.limit <= {NW{`PRC_LIMIT_RST}};
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign run_indicator = r.run;
  assign setting_error_indicator = r.err;
  assign error_offset_value = r.ofs;
  assign irq = r.irq;
endmodule : prc_unit
`default_nettype wire

// [verif/prc_host.sv]
`timescale 1ns/100ps
`default_nettype none
module prc_host (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // No cycle count assumed; only the bench timeout ends a hung wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : prc_host
`default_nettype wire

// [verif/prc_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
`include "prc_defs.svh"
module prc_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic run_indicator,
  input wire logic setting_error_indicator,
  input wire logic [15:0] error_offset_value
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence boot_done;
    ##[1:4] run_indicator;
  endsequence
  ofs_range_a: assert property (error_offset_value < 16'h0010 ||
    (error_offset_value >= 16'h0064 && error_offset_value < 16'h0074)) else $error("bad offset");
  grp1_ofs_a: assert property (setting_error_indicator && run_indicator
    |-> error_offset_value < 16'h0008) else $error("group 1 offset wrong");
  start_clean_a: assert property ($rose(run_indicator) |-> !setting_error_indicator)
    else $error("started with error lit");
  boot_run_a: assert property ($rose(aresetn) |-> boot_done) else $error("no start");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
  wr_drop_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("ready held after take");
  rd_upper_a: assert property (s_axi_rvalid && s_axi_rresp == `PRC_RESP_OKAY
    |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
endmodule : prc_asserts
bind prc_unit prc_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .run_indicator, .setting_error_indicator,
  .error_offset_value);
`default_nettype wire

// [verif/test_parameter_range_check_errors.sv]
`timescale 1ns/100ps
`default_nettype none
`include "prc_defs.svh"
module test_parameter_range_check_errors;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, r0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic run_indicator, setting_error_indicator, irq;
  logic [15:0] error_offset_value;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 aclk = ~aclk;
  prc_unit DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .run_indicator, .setting_error_indicator,
    .error_offset_value, .irq);
  prc_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk("bresp", `PRC_RESP_OKAY, r);
  endtask : w
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] re);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk("rresp", re, r);
    if (re == `PRC_RESP_OKAY) chk("rdata", e, d);
  endtask : rc
  // Run, error, offset; waits out the registered range check and restart
  task automatic ind(input logic [17:0] e);
    repeat (4) @(posedge aclk);
    chk("ind", e, {run_indicator, setting_error_indicator, error_offset_value});
  endtask : ind
  task automatic iq(input logic e);
    repeat (2) @(posedge aclk);
    chk("irq", e, irq);
  endtask : iq
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    ind({2'b10, 16'h0000});
    w(12'h40C, 32'h10);
    w(12'h10C, 32'h11);
    ind({2'b11, 16'h0003});
    rc(12'h20C, 32'h0, `PRC_RESP_OKAY);
    rc(`PRC_OFF_STATUS, 32'h3, `PRC_RESP_OKAY);
    rc(`PRC_OFF_IRQ_STAT, 32'h5, `PRC_RESP_OKAY);
    iq(1'b0);
    w(`PRC_OFF_IRQ_MASK, 32'h1);
    iq(1'b1);
    w(`PRC_OFF_IRQ_STAT, 32'h1);
    iq(1'b0);
    w(12'h404, 32'h10);
    w(12'h104, 32'h20);
    ind({2'b11, 16'h0001});
    w(12'h104, 32'h5);
    ind({2'b11, 16'h0003});
    w(12'h10C, 32'h10);
    ind({2'b10, 16'h0000});
    rc(12'h20C, 32'h10, `PRC_RESP_OKAY);
    w(12'h424, 32'h8);
    w(12'h124, 32'h9);
    ind({2'b10, 16'h0009});
    w(12'h124, 32'h8);
    ind({2'b10, 16'h0000});
    rc(12'h224, 32'h0, `PRC_RESP_OKAY);
    w(12'h444, 32'h0);
    w(12'h144, 32'h1);
    ind({2'b10, 16'h0065});
    w(`PRC_OFF_CTRL, 32'h1);
    ind({2'b01, 16'h0065});
    rc(`PRC_OFF_ERR_OFS, 32'h65, `PRC_RESP_OKAY);
    rc(`PRC_OFF_IRQ_STAT, 32'h6, `PRC_RESP_OKAY);
    w(12'h144, 32'h0);
    w(`PRC_OFF_CTRL, 32'h1);
    ind({2'b10, 16'h0000});
    rc(12'h224, 32'h8, `PRC_RESP_OKAY);
    rc(12'hFFC, 32'h0, `PRC_RESP_SLVERR);
    host.wr(12'hFF8, 32'h1, r0);
    chk("bresp", `PRC_RESP_SLVERR, r0);
    close_out;
  end
endmodule : test_parameter_range_check_errors
`default_nettype wire
